// File: hbp_pkg.sv
// Constants shared by the host bus buffer port and its output queue.
package hbp_pkg;

  // Width of the host data bus and of every buffer.
  localparam int HBP_DATA_W = 8;
  // Default depth of the firmware-to-host output queue.
  localparam int HBP_FIFO_DEPTH = 8;

  // Bit positions of the status byte seen by the master.
  localparam int HBP_ST_OUT_FULL = 0;
  localparam int HBP_ST_IN_FULL = 1;
  localparam int HBP_ST_USER_F0 = 2;
  localparam int HBP_ST_CMD_DATA = 3;
  localparam int HBP_ST_USER_LO = 4;
  localparam int HBP_ST_USER_W = 4;

  // Values taken at reset.
  localparam logic [7:0] HBP_BYTE_RST = 8'h00;
  localparam logic [3:0] HBP_USER_RST = 4'h0;
  localparam logic HBP_FLAG_RST = 1'b0;
  // Idle level of the active-low host strobes and chip select.
  localparam logic HBP_PIN_IDLE = 1'b1;

  // Value of the select line that addresses the status byte or a command.
  localparam logic HBP_SEL_STATUS = 1'b1;

  // Access the master is making, decoded from the synchronised pins.
  typedef enum logic [1:0] {
    HBP_ACC_IDLE = 2'b00,
    HBP_ACC_READ = 2'b01,
    HBP_ACC_WRITE = 2'b10
  } hbp_access_t;

endpackage : hbp_pkg

// File: hbp_stream_if.sv
// Valid/ready word stream between the port logic and its output queue.
`timescale 1ns/100ps
`default_nettype none

interface hbp_stream_if #(parameter int WIDTH = 8);
  logic valid;
  logic ready;
  logic [WIDTH-1:0] data;

  // Side that offers words.
  modport src (output valid, output data, input ready);
  // Side that takes words.
  modport snk (input valid, input data, output ready);
endinterface : hbp_stream_if

`default_nettype wire

// File: hbp_fifo.sv
// Synchronous FIFO with valid/ready on both sides.
`timescale 1ns/100ps
`default_nettype none

module hbp_fifo
  import hbp_pkg::*;
#(
  parameter int WIDTH = HBP_DATA_W,
  parameter int DEPTH = HBP_FIFO_DEPTH
)
(
  input wire logic i_clock,
  input wire logic i_reset_n,
  hbp_stream_if.snk fill,
  hbp_stream_if.src drain
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  // Occupancy at which no further word fits; one bit wider than the pointers.
  localparam logic [AW:0] CNT_FULL = DEPTH[AW:0];

  // Depth must be a power of two so the pointers wrap naturally.
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1)
  begin : g_bad_param
    $error("hbp_fifo: DEPTH must be a power of two of at least 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [AW:0] count_r;
  logic do_push;
  logic do_pop;

  ////////////////////////////////////////////////////////////////////////////
  // Handshake decode: full and empty come straight from the word count.
  assign fill.ready = (count_r != CNT_FULL);
  assign drain.valid = (count_r != '0);
  assign drain.data = mem[rd_ptr_r];
  assign do_push = fill.valid && fill.ready;
  assign do_pop = drain.valid && drain.ready;

  ////////////////////////////////////////////////////////////////////////////
  // Storage array, written on every accepted word.
  always_ff @(posedge i_clock)
  begin
    if (do_push)
    begin
      mem[wr_ptr_r] <= fill.data;
    end
  end

  // Pointers and occupancy.
  always_ff @(posedge i_clock or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
    end
    else
    begin
      if (do_push)
      begin
        wr_ptr_r <= wr_ptr_r + 1'b1;
      end
      if (do_pop)
      begin
        rd_ptr_r <= rd_ptr_r + 1'b1;
      end
      if (do_push && !do_pop)
      begin
        count_r <= count_r + 1'b1;
      end
      else if (do_pop && !do_push)
      begin
        count_r <= count_r - 1'b1;
      end
    end
  end

endmodule : hbp_fifo

`default_nettype wire

// File: hbp_host_port.sv
// Host bus buffer port: master-facing pins, buffers and status byte.
//
// Summary of operation
// - Selected read drives output buffer (select 0) or status (select 1); else bus floats.
// - Selected write stores data when select is 0, a command when select is 1.
// - Status byte: upper four firmware bits; low bits output-full, input-full, flag0, cmd/data.
// - Output-full sets on firmware push, clears when master reads output buffer.
// - Input-full sets on every selected master write, clears on firmware pull.
// - Firmware clears or complements flag zero; master sees it in status.
// - Every selected master write loads the command/data flag from the select line.
// - Firmware may also clear or complement the command/data flag.
// - Firmware push copies push data to output buffer, through the queue when it is busy, and sets output-full.
// - Master write strobe while selected captures bus byte and sets input-full.
// - Selected write latches the host-write pending flag and sets input-full.
`timescale 1ns/100ps
`default_nettype none

module hbp_host_port
  import hbp_pkg::*;
#(
  parameter int QUEUE_DEPTH = HBP_FIFO_DEPTH
)
(
  input wire logic i_clock,
  input wire logic i_reset_n,
  input wire logic i_chip_enable_n,
  input wire logic i_fetch_strobe_n,
  input wire logic i_load_strobe_n,
  input wire logic i_port_select,
  input wire logic [7:0] i_host_data_lines,
  output logic [7:0] o_host_data_lines,
  output logic o_host_data_lines_oe,
  input wire logic i_push_to_host,
  input wire logic [7:0] i_push_data,
  output logic o_push_ready,
  input wire logic i_pull_from_host,
  output logic [7:0] o_pull_data,
  input wire logic i_load_upper_status,
  input wire logic [3:0] i_upper_status,
  input wire logic i_flag0_clear,
  input wire logic i_flag0_toggle,
  input wire logic i_cmd_flag_clear,
  input wire logic i_cmd_flag_toggle,
  input wire logic i_write_pending_ack,
  output logic o_out_buffer_full,
  output logic o_in_buffer_full,
  output logic o_user_flag_zero,
  output logic o_command_data_flag,
  output logic o_host_write_pending
);

  // Two-stage synchronisers for every host pin.
  logic [11:0] pin_meta_r;
  logic [11:0] pin_sync_r;
  logic cs_n_s;
  logic rd_n_s;
  logic wr_n_s;
  logic sel_s;
  logic [7:0] data_s;
  hbp_access_t access;
  hbp_access_t access_prev_r;
  logic write_end;
  logic read_end;

  // Buffers and status.
  logic [7:0] out_buf_r;
  logic [7:0] in_buf_r;
  logic in_sel_r;
  logic obf_r;
  logic ibf_r;
  logic f0_r;
  logic f1_r;
  logic [3:0] user_r;
  logic pending_r;
  logic load_direct;
  logic [7:0] status_byte;

  hbp_stream_if #(.WIDTH(HBP_DATA_W)) q_fill ();
  hbp_stream_if #(.WIDTH(HBP_DATA_W)) q_drain ();

  // Toggle/clear update shared by both firmware-controlled flags.
  function automatic logic flag_update(input logic cur, input logic clr, input logic tgl);
    logic res;
    res = cur;
    if (clr)
    begin
      res = 1'b0;
    end
    else if (tgl)
    begin
      res = ~cur;
    end
    return res;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Host pin synchronisers; only the second stage is read by logic.
  always_ff @(posedge i_clock or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      pin_meta_r <= {HBP_PIN_IDLE, HBP_PIN_IDLE, HBP_PIN_IDLE, 1'b0, HBP_BYTE_RST};
      pin_sync_r <= {HBP_PIN_IDLE, HBP_PIN_IDLE, HBP_PIN_IDLE, 1'b0, HBP_BYTE_RST};
    end
    else
    begin
      pin_meta_r <= {i_chip_enable_n, i_fetch_strobe_n, i_load_strobe_n, i_port_select,
                     i_host_data_lines};
      pin_sync_r <= pin_meta_r;
    end
  end

  assign {cs_n_s, rd_n_s, wr_n_s, sel_s, data_s} = pin_sync_r;

  // Decode the access; a strobe only counts while chip select is low.
  always_comb
  begin
    access = HBP_ACC_IDLE;
    if (!cs_n_s && !rd_n_s && wr_n_s)
    begin
      access = HBP_ACC_READ;
    end
    else if (!cs_n_s && !wr_n_s && rd_n_s)
    begin
      access = HBP_ACC_WRITE;
    end
  end

  always_ff @(posedge i_clock or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      access_prev_r <= HBP_ACC_IDLE;
    end
    else
    begin
      access_prev_r <= access;
    end
  end

  // An access completes on the cycle its decode falls away.
  assign write_end = (access_prev_r == HBP_ACC_WRITE) && (access != HBP_ACC_WRITE);
  assign read_end = (access_prev_r == HBP_ACC_READ) && (access != HBP_ACC_READ);

  ////////////////////////////////////////////////////////////////////////////
  // Status byte as the master sees it.
  // status byte layout
  always_comb
  begin
    status_byte = HBP_BYTE_RST;
    status_byte[HBP_ST_OUT_FULL] = obf_r;
    status_byte[HBP_ST_IN_FULL] = ibf_r;
    status_byte[HBP_ST_USER_F0] = f0_r;
    status_byte[HBP_ST_CMD_DATA] = f1_r;
    status_byte[HBP_ST_USER_LO +: HBP_ST_USER_W] = user_r;
  end

  // Read data and enable come from flops; the bus floats when not selected.
  // read mux, float
  always_ff @(posedge i_clock or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_host_data_lines <= HBP_BYTE_RST;
      o_host_data_lines_oe <= 1'b0;
    end
    else
    begin
      o_host_data_lines_oe <= (access == HBP_ACC_READ);
      if (access == HBP_ACC_READ)
      begin
        o_host_data_lines <= (sel_s == HBP_SEL_STATUS) ? status_byte : out_buf_r;
      end
      else
      begin
        o_host_data_lines <= HBP_BYTE_RST;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Input buffer follows the bus while the write strobe is held, so the
  // value kept is the last one sampled inside the strobe.
  // capture written byte
  always_ff @(posedge i_clock or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      in_buf_r <= HBP_BYTE_RST;
      in_sel_r <= 1'b0;
    end
    else if (access == HBP_ACC_WRITE)
    begin
      in_buf_r <= data_s;
      in_sel_r <= sel_s;
    end
  end

  // Input-full and the write-pending flag; a new write wins over a clear.
  // input-full set/clear
  always_ff @(posedge i_clock or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      ibf_r <= HBP_FLAG_RST;
      pending_r <= HBP_FLAG_RST;
    end
    else
    begin
      ibf_r <= write_end | (ibf_r & ~i_pull_from_host);
      pending_r <= write_end | (pending_r & ~i_write_pending_ack);
    end
  end

  // Firmware user flag and upper status nibble.
  // flag zero control
  always_ff @(posedge i_clock or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      f0_r <= HBP_FLAG_RST;
      user_r <= HBP_USER_RST;
    end
    else
    begin
      f0_r <= flag_update(f0_r, i_flag0_clear, i_flag0_toggle);
      if (i_load_upper_status)
      begin
        user_r <= i_upper_status;
      end
    end
  end

  // Command/data flag: a master write takes priority over firmware action.
  // load from select
  always_ff @(posedge i_clock or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      f1_r <= HBP_FLAG_RST;
    end
    else if (write_end)
    begin
      f1_r <= in_sel_r;
    end
    else
    begin
      f1_r <= flag_update(f1_r, i_cmd_flag_clear, i_cmd_flag_toggle);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output path: a push goes straight to the buffer when it and the queue are
  // empty, otherwise it waits in the queue behind earlier bytes.
  assign load_direct = i_push_to_host && !obf_r && !q_drain.valid;
  assign q_fill.valid = i_push_to_host && !load_direct;
  assign q_fill.data = i_push_data;
  assign q_drain.ready = !obf_r;

  hbp_fifo #(
    .WIDTH(HBP_DATA_W),
    .DEPTH(QUEUE_DEPTH)
  ) u_out_queue (
    .i_clock(i_clock),
    .i_reset_n(i_reset_n),
    .fill(q_fill.snk),
    .drain(q_drain.src)
  );

  // Output buffer and output-full; a load in the read-end cycle wins.
  // push loads buffer
  always_ff @(posedge i_clock or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      out_buf_r <= HBP_BYTE_RST;
      obf_r <= HBP_FLAG_RST;
    end
    else if (load_direct)
    begin
      out_buf_r <= i_push_data;
      obf_r <= 1'b1;
    end
    else if (!obf_r && q_drain.valid)
    begin
      out_buf_r <= q_drain.data;
      obf_r <= 1'b1;
    end
    else if (read_end && (sel_s != HBP_SEL_STATUS) && (access_prev_r == HBP_ACC_READ))
    begin
      obf_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered copies toward firmware.
  always_ff @(posedge i_clock or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_pull_data <= HBP_BYTE_RST;
      o_push_ready <= 1'b0;
      o_out_buffer_full <= HBP_FLAG_RST;
      o_in_buffer_full <= HBP_FLAG_RST;
      o_user_flag_zero <= HBP_FLAG_RST;
      o_command_data_flag <= HBP_FLAG_RST;
      o_host_write_pending <= HBP_FLAG_RST;
    end
    else
    begin
      o_pull_data <= in_buf_r;
      o_push_ready <= q_fill.ready & ~(i_push_to_host & ~load_direct);
      o_out_buffer_full <= obf_r;
      o_in_buffer_full <= ibf_r;
      o_user_flag_zero <= f0_r;
      o_command_data_flag <= f1_r;
      o_host_write_pending <= pending_r;
    end
  end

endmodule : hbp_host_port

`default_nettype wire

// File: hbp_host_port_asserts.sv
// Concurrent checks on the host bus buffer port pins.
`timescale 1ns/100ps
`default_nettype none
module hbp_host_port_asserts
  import hbp_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_reset_n,
  input wire logic i_chip_enable_n,
  input wire logic i_fetch_strobe_n,
  input wire logic i_load_strobe_n,
  input wire logic i_port_select,
  input wire logic i_push_to_host,
  input wire logic i_pull_from_host,
  input wire logic i_load_upper_status,
  input wire logic [3:0] i_upper_status,
  input wire logic i_flag0_clear,
  input wire logic [7:0] o_host_data_lines,
  input wire logic o_host_data_lines_oe,
  input wire logic o_push_ready,
  input wire logic o_out_buffer_full,
  input wire logic o_in_buffer_full,
  input wire logic o_user_flag_zero,
  input wire logic o_command_data_flag,
  input wire logic o_host_write_pending
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_reset_n);
  logic [3:0] nib_r;
  ////////////////////////////////////////
  // Keeps the nibble that firmware last loaded.
  always_ff @(posedge i_clock or negedge i_reset_n)
    if (!i_reset_n) nib_r <= HBP_USER_RST;
    else if (i_load_upper_status) nib_r <= i_upper_status;
  // A finished selected write sets input-full, pending and the select copy.
  property p_wr(logic s);
    (!i_chip_enable_n && !i_load_strobe_n && i_fetch_strobe_n && i_port_select == s)[*3]
      ##1 i_load_strobe_n |-> ##[1:6]
      (o_in_buffer_full && o_host_write_pending && o_command_data_flag == s);
  endproperty
  a_bus_floats_idle: assert property (i_chip_enable_n[*5] |-> !o_host_data_lines_oe)
    else $error("bus driven while deselected");
  a_idle_data_zero: assert property (!o_host_data_lines_oe |-> o_host_data_lines == 8'h00)
    else $error("data not zero while floating");
  a_push_sets_full: assert property (i_push_to_host && o_push_ready
    |-> ##[1:3] o_out_buffer_full)
    else $error("push did not set output-full");
  a_data_write_flags: assert property (p_wr(1'b0))
    else $error("data write flags wrong");
  a_cmd_write_flags: assert property (p_wr(1'b1))
    else $error("command write flags wrong");
  a_pull_clears_full: assert property (i_load_strobe_n[*5] ##0 i_pull_from_host
    |-> ##[1:3] !o_in_buffer_full)
    else $error("pull did not clear input-full");
  a_flag_zero_clear: assert property (i_flag0_clear |-> ##[1:3] !o_user_flag_zero)
    else $error("flag zero not cleared");
  // Four low samples reach back to the pin state behind the byte now driven.
  a_status_upper_bits: assert property ((!i_chip_enable_n && !i_fetch_strobe_n
    && i_load_strobe_n && i_port_select && !i_load_upper_status)[*4]
    |-> o_host_data_lines[7:4] == nib_r)
    else $error("upper status bits wrong");
  c_queue_full: cover property (o_out_buffer_full && !o_push_ready);
  c_status_read: cover property (o_host_data_lines_oe && i_port_select);
  c_cmd_write: cover property ($rose(o_command_data_flag));
endmodule // hbp_host_port_asserts
bind hbp_host_port hbp_host_port_asserts u_hbp_host_port_asserts (.*);
`default_nettype wire

// File: hbp_master_model.sv
// Behavioural master processor on the asynchronous host bus.
`timescale 1ns/100ps
`default_nettype none
module hbp_master_model
(
  input wire logic i_clock,
  input wire logic [7:0] i_dev_data,
  input wire logic i_dev_oe,
  output logic o_cs_n,
  output logic o_rd_n,
  output logic o_wr_n,
  output logic o_sel,
  output logic [7:0] o_bus,
  output logic o_rd_valid,
  output logic [7:0] o_rd_data
);
  logic [7:0] drv;
  logic drv_en;
  logic flip = 1'b0;
  ////////////////////////////////////////
  // Start idle; an undriven bus shows a pattern that changes every cycle.
  initial
  begin
    {o_cs_n, o_rd_n, o_wr_n, o_sel, drv_en, o_rd_valid} = 6'h38;
    {drv, o_rd_data} = 16'h0000;
  end
  always @(posedge i_clock) flip <= !flip;
  assign o_bus = i_dev_oe ? i_dev_data : drv_en ? drv : ({8{flip}} ^ 8'h5a);
  // One access: strobe low five cycles, then idle four.
  task automatic access(input logic wr, input logic sel, input logic [7:0] d,
                        input logic note, output logic [7:0] q);
    @(negedge i_clock);
    {o_cs_n, o_sel, drv, drv_en, o_rd_n, o_wr_n} = {1'b0, sel, d, wr, wr, !wr};
    repeat (5) @(posedge i_clock);
    // Take the read byte where it has settled, just before the strobe rises.
    @(negedge i_clock);
    q = o_bus;
    {o_cs_n, o_rd_n, o_wr_n, drv_en, o_rd_data, o_rd_valid} = {4'he, q, note & !wr};
    @(negedge i_clock);
    o_rd_valid = 1'b0;
    repeat (3) @(negedge i_clock);
  endtask
  task automatic poll(input int idx, input logic val, output logic [7:0] q);
    for (int n = 0; n < 16; n++)
    begin
      access(1'b0, 1'b1, 8'h00, 1'b0, q);
      if (q[idx] === val) break;
    end
  endtask
endmodule // hbp_master_model
`default_nettype wire

// File: tb_hbp_host_port.sv
// Self-checking testbench of the host bus buffer port.
`timescale 1ns/100ps
`default_nettype none
module tb_hbp_host_port;
  import hbp_pkg::*;
  logic i_clock = 0, i_reset_n = 0, i_push_to_host = 0, i_pull_from_host = 0;
  logic i_load_upper_status = 0, i_flag0_clear = 0, i_flag0_toggle = 0;
  logic i_cmd_flag_clear = 0, i_cmd_flag_toggle = 0, i_write_pending_ack = 0;
  logic [7:0] i_push_data = 0, o_host_data_lines, o_pull_data, i_host_data_lines, rdd, d, q;
  logic [3:0] i_upper_status = 0;
  logic i_chip_enable_n, i_fetch_strobe_n, i_load_strobe_n, i_port_select, rdv;
  logic o_host_data_lines_oe, o_push_ready, o_out_buffer_full, o_in_buffer_full;
  logic o_user_flag_zero, o_command_data_flag, o_host_write_pending;
  logic e_obf = 0, e_ibf = 0, e_f0 = 0, e_cf = 0;
  logic [3:0] e_nib = 0;
  logic [7:0] expq[$], fq[$];
  int failures = 0, checks_done = 0, cycles = 0;
  ////////////////////////////////////////
  always #4 i_clock = !i_clock;
  hbp_host_port #(.QUEUE_DEPTH(2)) u_hbp_host_port (.*);
  hbp_master_model u_hbp_master_model (.i_clock(i_clock), .i_dev_data(o_host_data_lines),
    .i_dev_oe(o_host_data_lines_oe), .o_cs_n(i_chip_enable_n), .o_rd_n(i_fetch_strobe_n),
    .o_wr_n(i_load_strobe_n), .o_sel(i_port_select), .o_bus(i_host_data_lines),
    .o_rd_valid(rdv), .o_rd_data(rdd));
  task automatic conclude;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk_byte(input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e)
    begin
      failures++;
      $display("unexpected at %0t: expected %h got %h", $time, e, g);
    end
  endtask
  task automatic chk_bit(input logic e, input logic g);
    chk_byte({7'h00, e}, {7'h00, g});
  endtask
  task automatic pulse(ref logic s);
    @(negedge i_clock);
    s = 1'b1;
    @(negedge i_clock);
    s = 1'b0;
  endtask
  task automatic rd(input logic sel, input logic [7:0] e);
    expq.push_back(e);
    u_hbp_master_model.access(1'b0, sel, 8'h00, 1'b1, q);
  endtask
  function automatic logic [7:0] st();
    return {e_nib, e_cf, e_f0, e_ibf, e_obf};
  endfunction
  // Each finished master read made with note set takes the oldest noted value.
  always @(posedge i_clock)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      failures++;
      conclude();
    end
    if (rdv === 1'b1)
      chk_byte(expq.size() ? expq.pop_front() : ~rdd, rdd);
  end
  initial
  begin
    d = $urandom(32'hd578);
    repeat (5) @(negedge i_clock);
    i_reset_n = 1;
    @(negedge i_clock);
    q = {4'h0, o_command_data_flag, o_user_flag_zero, o_in_buffer_full, o_out_buffer_full};
    chk_byte(8'h00, q);
    rd(1'b1, st());
    $display("reset test done");
    i_push_data = $urandom;
    pulse(i_push_to_host);
    u_hbp_master_model.poll(HBP_ST_OUT_FULL, 1'b1, q);
    chk_bit(1'b1, q[HBP_ST_OUT_FULL]);
    chk_bit(1'b1, o_out_buffer_full);
    rd(1'b0, i_push_data);
    rd(1'b1, st());
    chk_bit(1'b0, o_out_buffer_full);
    $display("push test done");
    // Push until the port refuses; ready is looked at one cycle after each push.
    for (int n = 0; n < 16; n++)
    begin
      @(negedge i_clock);
      if (o_push_ready !== 1'b1)
        break;
      i_push_data = $urandom;
      fq.push_back(i_push_data);
      pulse(i_push_to_host);
    end
    // One byte in the output buffer plus a full queue of two.
    chk_byte(8'h03, 8'(fq.size()));
    i_push_data = ~fq[0];
    pulse(i_push_to_host);
    foreach (fq[i]) rd(1'b0, fq[i]);
    rd(1'b1, st());
    $display("queue test done");
    for (int s = 0; s < 2; s++)
    begin
      d = $urandom;
      u_hbp_master_model.access(1'b1, s[0], d, 1'b0, q);
      {e_ibf, e_cf} = {1'b1, s[0]};
      rd(1'b1, st());
      chk_byte(d, o_pull_data);
      chk_bit(1'b1, o_host_write_pending);
      pulse(i_write_pending_ack);
      pulse(i_pull_from_host);
      e_ibf = 0;
      rd(1'b1, st());
      chk_bit(1'b0, o_host_write_pending);
    end
    $display("write test done");
    pulse(i_flag0_toggle);
    pulse(i_cmd_flag_toggle);
    {e_f0, e_cf} = {1'b1, !e_cf};
    rd(1'b1, st());
    // Set the command flag again so that its clear has something to undo.
    pulse(i_cmd_flag_toggle);
    pulse(i_flag0_clear);
    pulse(i_cmd_flag_clear);
    {e_f0, e_cf} = 2'b00;
    rd(1'b1, st());
    i_upper_status = 4'($urandom);
    pulse(i_load_upper_status);
    e_nib = i_upper_status;
    rd(1'b1, st());
    $display("flag test done");
    conclude();
  end
endmodule // tb_hbp_host_port
`default_nettype wire
